// >>> include/fcu_pkg.sv
package fcu_pkg;

    // register index; the byte address on the bus is four times the index
    typedef logic [9:0] fcu_idx_t;

    localparam fcu_idx_t IDX_NVLOAD_CLR   = 10'h139;
    localparam fcu_idx_t IDX_RAIL_CLR     = 10'h13A;
    localparam fcu_idx_t IDX_SYS1_CLR     = 10'h13B;
    localparam fcu_idx_t IDX_SYS2_CLR     = 10'h13C;
    localparam fcu_idx_t IDX_SYS3_CLR     = 10'h13D;
    localparam fcu_idx_t IDX_VST_CLR      = 10'h13E;
    localparam fcu_idx_t IDX_TST_CLR      = 10'h13F;
    localparam fcu_idx_t IDX_PROG_CTRL    = 10'h14F;
    localparam fcu_idx_t IDX_UNLOCK_1     = 10'h150;
    localparam fcu_idx_t IDX_UNLOCK_2     = 10'h151;
    localparam fcu_idx_t IDX_UNLOCK_3     = 10'h152;
    localparam fcu_idx_t IDX_UNLOCK_4     = 10'h153;
    localparam fcu_idx_t IDX_IRQ_STATUS   = 10'h160;
    localparam fcu_idx_t IDX_IRQ_MASK     = 10'h161;
    localparam fcu_idx_t IDX_UNLOCK_STAT  = 10'h162;
    localparam fcu_idx_t IDX_NONE         = 10'h3FF;

    // writable clear bits of each register
    localparam logic [7:0] MASK_NVLOAD    = 8'h07;
    localparam logic [7:0] MASK_RAIL      = 8'hFF;
    localparam logic [7:0] MASK_SYS1      = 8'h5F;
    localparam logic [7:0] MASK_SYS2      = 8'hFF;
    localparam logic [7:0] MASK_SYS3      = 8'h7F;
    localparam logic [7:0] MASK_VST       = 8'h03;
    localparam logic [7:0] MASK_TST       = 8'hFF;

    // field positions
    localparam int unsigned PROGRAM_GO_BIT   = 0;
    localparam int unsigned IRQ_W         = 4;
    localparam int unsigned IRQ_FAULT     = 0;
    localparam int unsigned IRQ_UNLOCKED  = 1;
    localparam int unsigned IRQ_LOST      = 2;
    localparam int unsigned IRQ_PROGRAM_GO   = 3;

    // reset values
    localparam logic [3:0]  IRQ_MASK_RST  = 4'h0;
    localparam logic [31:0] RDATA_RST     = 32'h0000_0000;

    // latched fault flags, one field per clear register
    typedef struct packed {
        logic [2:0] nvload;
        logic [7:0] tst;
        logic [1:0] vst;
        logic [7:0] sys3;
        logic [7:0] sys2;
        logic [7:0] sys1;
        logic [7:0] rail;
    } fcu_fault_s;

    typedef enum logic [2:0] {
        UL_IDLE,
        UL_GOT1,
        UL_GOT2,
        UL_GOT3,
        UL_OPEN
    } fcu_unlock_e;

endpackage

// >>> logic/fcu_top.sv
`timescale 1ns/1ps
module fcu_top (
    // clock and reset
    input  wire logic               ref_clk,
    input  wire logic               rst_n,
    // ahb-lite slave
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic      [31:0]        hrdata,
    output logic                    hreadyout,
    output logic                    hresp,
    // fault detectors and latched flags
    input  wire fcu_pkg::fcu_fault_s fault_event,
    output fcu_pkg::fcu_fault_s     fault_flags,
    // programming control
    input  wire logic               first_stage_ok,
    output logic                    program_unlocked,
    output logic                    program_go,
    // interrupt
    output logic                    irq
);

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // maps a byte address to a register index; misaligned or out of range is unmapped
    function automatic fcu_pkg::fcu_idx_t addr_to_idx(input logic [31:0] a);
        if (a[1:0] != 2'b00 || a[31:12] != 20'h00000) begin
            return fcu_pkg::IDX_NONE;
        end
        return a[11:2];
    endfunction

    // one flag group: clear first, then a fresh event sets it again
    function automatic logic [7:0] flag_next(input logic [7:0] q, input logic [7:0] ev,
                                             input logic [7:0] clr, input logic [7:0] msk);
        return ((q & ~(clr & msk)) | (ev & msk));
    endfunction

    // registers that read back as zero whatever was written
    function automatic logic reads_zero(input fcu_pkg::fcu_idx_t i);
        return (i >= fcu_pkg::IDX_NVLOAD_CLR && i <= fcu_pkg::IDX_TST_CLR)
            || (i >= fcu_pkg::IDX_UNLOCK_1 && i <= fcu_pkg::IDX_UNLOCK_4)
            || (i == fcu_pkg::IDX_PROG_CTRL);
    endfunction

    fcu_pkg::fcu_idx_t      ap_idx;
    logic                   ap_take;
    logic                   ap_read;
    logic                   dp_valid_q;
    logic                   dp_write_q;
    fcu_pkg::fcu_idx_t      dp_idx_q;
    logic                   wr;
    logic [7:0]             wdat;
    logic                   rd_zero_q;
    fcu_pkg::fcu_fault_s    flags_q;
    fcu_pkg::fcu_fault_s    flags_d;
    fcu_pkg::fcu_unlock_e   ul_q;
    fcu_pkg::fcu_unlock_e   ul_d;
    logic                   go_q;
    logic                   go_d;
    logic [3:0]             irq_stat_q;
    logic [3:0]             irq_mask_q;
    logic [3:0]             irq_ev;
    logic                   stat_rd;
    logic [31:0]            rdata_q;
    logic [31:0]            rdata_d;

    // zero-wait slave: every transfer completes in one data-phase cycle, always okay
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // address phase decode
    assign ap_idx  = addr_to_idx(haddr);
    assign ap_take = hsel & htrans[1] & hready;
    assign ap_read = ap_take & ~hwrite;

    // address phase is held over into the data phase, where hwdata stands
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dp_valid_q <= 1'b0;
            dp_write_q <= 1'b0;
            dp_idx_q   <= fcu_pkg::IDX_NONE;
        end else if (hready) begin
            dp_valid_q <= ap_take;
            dp_write_q <= hwrite;
            dp_idx_q   <= ap_idx;
        end
    end

    assign wr   = dp_valid_q & dp_write_q;
    assign wdat = hwdata[7:0];

    // fault flags: a clear acts only in the write's data-phase cycle
    always_comb begin
        flags_d = flags_q;
        flags_d.rail = flag_next(flags_q.rail, fault_event.rail,
            (wr && dp_idx_q == fcu_pkg::IDX_RAIL_CLR) ? wdat : 8'h00,
            fcu_pkg::MASK_RAIL);
        flags_d.sys1 = flag_next(flags_q.sys1, fault_event.sys1,
            (wr && dp_idx_q == fcu_pkg::IDX_SYS1_CLR) ? wdat : 8'h00,
            fcu_pkg::MASK_SYS1);
        flags_d.sys2 = flag_next(flags_q.sys2, fault_event.sys2,
            (wr && dp_idx_q == fcu_pkg::IDX_SYS2_CLR) ? wdat : 8'h00,
            fcu_pkg::MASK_SYS2);
        flags_d.sys3 = flag_next(flags_q.sys3, fault_event.sys3,
            (wr && dp_idx_q == fcu_pkg::IDX_SYS3_CLR) ? wdat : 8'h00,
            fcu_pkg::MASK_SYS3);
        flags_d.vst = 2'(flag_next({6'h00, flags_q.vst}, {6'h00, fault_event.vst},
            (wr && dp_idx_q == fcu_pkg::IDX_VST_CLR) ? wdat : 8'h00,
            fcu_pkg::MASK_VST));
        flags_d.tst = flag_next(flags_q.tst, fault_event.tst,
            (wr && dp_idx_q == fcu_pkg::IDX_TST_CLR) ? wdat : 8'h00,
            fcu_pkg::MASK_TST);
        // load faults come straight back while the cause persists, so software rereads
        flags_d.nvload = 3'(flag_next({5'h00, flags_q.nvload},
            {5'h00, fault_event.nvload},
            (wr && dp_idx_q == fcu_pkg::IDX_NVLOAD_CLR) ? wdat : 8'h00,
            fcu_pkg::MASK_NVLOAD));
    end

    // set beats clear in the same cycle so no fault event is lost
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_q <= '0;
        end else begin
            flags_q <= flags_d;
        end
    end

    assign fault_flags = flags_q;

    a_flag_cleared: assert property (
        (wr && dp_idx_q == fcu_pkg::IDX_RAIL_CLR)
        |=> ((flags_q.rail & $past(wdat & ~fault_event.rail)) == 8'h00))
        else $error("rail flag survived its clear");

    a_flag_holds: assert property (
        (!wr && fault_event.sys2 == 8'h00) |=> $stable(flags_q.sys2))
        else $error("system flag changed without a write or event");

    a_flag_resets: assert property (
        (fault_event.tst != 8'h00) |=> ((flags_q.tst & $past(fault_event.tst))
                                        == $past(fault_event.tst)))
        else $error("present fault did not set its flag again");

    a_spare_zero: assert property (
        ((flags_q.sys1 & ~fcu_pkg::MASK_SYS1) == 8'h00)
        && ((flags_q.sys3 & ~fcu_pkg::MASK_SYS3) == 8'h00))
        else $error("spare or reserved flag bit set");

    // unlock sequencer: any write steps it, forward only on the expected register
    always_comb begin
        ul_d = ul_q;
        if (wr) begin
            case (ul_q)
                fcu_pkg::UL_IDLE: begin
                    ul_d = (dp_idx_q == fcu_pkg::IDX_UNLOCK_1) ? fcu_pkg::UL_GOT1
                                                               : fcu_pkg::UL_IDLE;
                end
                fcu_pkg::UL_GOT1: begin
                    if (dp_idx_q == fcu_pkg::IDX_UNLOCK_2) begin
                        ul_d = fcu_pkg::UL_GOT2;
                    end else if (dp_idx_q == fcu_pkg::IDX_UNLOCK_1) begin
                        ul_d = fcu_pkg::UL_GOT1;
                    end else begin
                        ul_d = fcu_pkg::UL_IDLE;
                    end
                end
                fcu_pkg::UL_GOT2: begin
                    if (dp_idx_q == fcu_pkg::IDX_UNLOCK_3) begin
                        ul_d = fcu_pkg::UL_GOT3;
                    end else if (dp_idx_q == fcu_pkg::IDX_UNLOCK_1) begin
                        ul_d = fcu_pkg::UL_GOT1;
                    end else begin
                        ul_d = fcu_pkg::UL_IDLE;
                    end
                end
                fcu_pkg::UL_GOT3: begin
                    if (dp_idx_q == fcu_pkg::IDX_UNLOCK_4) begin
                        ul_d = fcu_pkg::UL_OPEN;
                    end else if (dp_idx_q == fcu_pkg::IDX_UNLOCK_1) begin
                        ul_d = fcu_pkg::UL_GOT1;
                    end else begin
                        ul_d = fcu_pkg::UL_IDLE;
                    end
                end
                fcu_pkg::UL_OPEN: begin
                    ul_d = fcu_pkg::UL_IDLE;
                end
                default: begin
                    ul_d = fcu_pkg::UL_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ul_q <= fcu_pkg::UL_IDLE;
        end else begin
            ul_q <= ul_d;
        end
    end

    assign program_unlocked = (ul_q == fcu_pkg::UL_OPEN);

    // go only on the write right after the unlock, and only with the first stage confirmed
    assign go_d = wr && program_unlocked && dp_idx_q == fcu_pkg::IDX_PROG_CTRL
                  && wdat[fcu_pkg::PROGRAM_GO_BIT] && first_stage_ok;

    // one-cycle program pulse, registered so the programmer sees a clean edge
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            go_q <= 1'b0;
        end else begin
            go_q <= go_d;
        end
    end

    assign program_go = go_q;

    a_unlock_order: assert property (
        $rose(program_unlocked) |-> ($past(ul_q) == fcu_pkg::UL_GOT3)
        && $past(wr) && ($past(dp_idx_q) == fcu_pkg::IDX_UNLOCK_4))
        else $error("unlock opened without the fourth write in order");

    a_unlock_drop: assert property (
        (program_unlocked && wr) |=> !program_unlocked)
        else $error("unlock survived the next write");

    a_go_stages: assert property (
        program_go |-> ($past(program_unlocked) && $past(first_stage_ok))
        ##1 !program_go)
        else $error("program go without both stages or held too long");

    a_restart_seq: assert property (
        (wr && ul_q == fcu_pkg::UL_GOT2 && dp_idx_q != fcu_pkg::IDX_UNLOCK_3
         && dp_idx_q != fcu_pkg::IDX_UNLOCK_1) |=> ul_q == fcu_pkg::UL_IDLE)
        else $error("foreign write did not restart the unlock sequence");

    // interrupt events
    assign irq_ev[fcu_pkg::IRQ_FAULT]    = |(flags_d & ~flags_q);
    assign irq_ev[fcu_pkg::IRQ_UNLOCKED] = (ul_d == fcu_pkg::UL_OPEN) && !program_unlocked;
    assign irq_ev[fcu_pkg::IRQ_LOST]     = program_unlocked && wr && !go_d;
    assign irq_ev[fcu_pkg::IRQ_PROGRAM_GO]  = go_d;

    // status is cleared by the read's address phase; a same-cycle event still lands
    assign stat_rd = ap_read && ap_idx == fcu_pkg::IDX_IRQ_STATUS;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_q <= '0;
        end else begin
            irq_stat_q <= (stat_rd ? 4'h0 : irq_stat_q) | irq_ev;
        end
    end

    // mask register, software writable
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_mask_q <= fcu_pkg::IRQ_MASK_RST;
        end else if (wr && dp_idx_q == fcu_pkg::IDX_IRQ_MASK) begin
            irq_mask_q <= hwdata[fcu_pkg::IRQ_W-1:0];
        end
    end

    assign irq = |(irq_stat_q & irq_mask_q);

    // a write that wastes the unlock must leave a trace software can see
    a_lost_flag: assert property (
        (program_unlocked && wr && !go_d) |=> irq_stat_q[fcu_pkg::IRQ_LOST])
        else $error("lost unlock not recorded in status");

    a_irq_level: assert property (
        (irq_stat_q & irq_mask_q) != 4'h0 |-> irq)
        else $error("irq low with an unmasked status bit");

    // read data is chosen in the address phase and stands from a flop in the data phase
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (ap_read) begin
            case (ap_idx)
                fcu_pkg::IDX_IRQ_STATUS: rdata_d = {28'h0000000, irq_stat_q};
                fcu_pkg::IDX_IRQ_MASK:   rdata_d = {28'h0000000, irq_mask_q};
                fcu_pkg::IDX_UNLOCK_STAT: begin
                    rdata_d = {29'h0000000, ul_q};
                end
                // clear and unlock registers are write-only in effect
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q   <= fcu_pkg::RDATA_RST;
            rd_zero_q <= 1'b0;
        end else begin
            rdata_q   <= rdata_d;
            rd_zero_q <= ap_read && reads_zero(ap_idx);
        end
    end

    assign hrdata = rdata_q;

    a_clear_reads_zero: assert property (
        rd_zero_q |-> hrdata == 32'h0000_0000)
        else $error("clear register read back nonzero");

    a_unlock_reads_zero: assert property (
        (ap_read && ap_idx >= fcu_pkg::IDX_UNLOCK_1 && ap_idx <= fcu_pkg::IDX_UNLOCK_4)
        |=> hrdata == 32'h0000_0000)
        else $error("unlock register read back nonzero");

    // hsize is accepted but only whole words are meaningful here
    logic unused_hsize;
    assign unused_hsize = ^hsize;

endmodule

// >>> verification/fcu_top_test.sv
`timescale 1ns/1ps
module fcu_top_test;
    localparam int FW = $bits(fcu_pkg::fcu_fault_s);
    localparam int OFF [7] = '{42, 0, 8, 16, 24, 32, 34};
    localparam logic [7:0] EVT [7] = '{8'h07, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h03, 8'hFF};
    localparam logic [7:0] MSK [7] = '{fcu_pkg::MASK_NVLOAD, fcu_pkg::MASK_RAIL,
        fcu_pkg::MASK_SYS1, fcu_pkg::MASK_SYS2, fcu_pkg::MASK_SYS3, fcu_pkg::MASK_VST,
        fcu_pkg::MASK_TST};
    localparam fcu_pkg::fcu_idx_t IDX [7] = '{fcu_pkg::IDX_NVLOAD_CLR, fcu_pkg::IDX_RAIL_CLR,
        fcu_pkg::IDX_SYS1_CLR, fcu_pkg::IDX_SYS2_CLR, fcu_pkg::IDX_SYS3_CLR,
        fcu_pkg::IDX_VST_CLR, fcu_pkg::IDX_TST_CLR};
    logic                ref_clk;
    logic                rst_n;
    logic                hsel;
    logic [31:0]         haddr;
    logic [1:0]          htrans;
    logic                hwrite;
    logic [2:0]          hsize;
    logic [31:0]         hwdata;
    logic                hready;
    logic [31:0]         hrdata;
    logic                hreadyout;
    logic                hresp;
    fcu_pkg::fcu_fault_s fault_event;
    fcu_pkg::fcu_fault_s fault_flags;
    logic                first_stage_ok;
    logic                program_unlocked;
    logic                program_go;
    logic                irq;
    logic [31:0]         rd;
    int                  num_errors;
    int                  check_count;
    int                  cycles;
    int                  go_count;

    // single slave, so its ready is the bus ready
    assign hready = hreadyout;

    fcu_top u_dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .fault_event(fault_event),
        .fault_flags(fault_flags), .first_stage_ok(first_stage_ok),
        .program_unlocked(program_unlocked), .program_go(program_go), .irq(irq)
    );

    // clock generation
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // counts start pulses and cuts a hang short
    always @(posedge ref_clk) begin
        cycles++;
        if (program_go === 1'b1) go_count++;
        if (cycles == 20000) begin
            num_errors++;
            finish_test();
        end
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // one single ahb-lite word transfer; entered just after a rising edge
    task automatic bus(input logic wr, input fcu_pkg::fcu_idx_t idx, input logic [31:0] wd);
        hsel   <= 1'b1;
        haddr  <= {20'h00000, idx, 2'h0};
        hwrite <= wr;
        htrans <= 2'h2;
        hsize  <= 3'h2;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) @(posedge ref_clk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) @(posedge ref_clk);
        rd = hrdata;
    endtask

    task automatic wr_list(input fcu_pkg::fcu_idx_t l [$]);
        foreach (l[i]) bus(1'b1, l[i], 32'h0000_005A);
    endtask

    task automatic unlock_stat(input logic [63:0] exp);
        bus(1'b0, fcu_pkg::IDX_UNLOCK_STAT, 32'h0);
        check(rd, exp, "unlock state");
    endtask

    // interrupt masked, unmasked, read-cleared
    task automatic t_irq();
        bus(1'b0, fcu_pkg::IDX_IRQ_MASK, 32'h0);
        check(rd, fcu_pkg::IRQ_MASK_RST, "mask reset");
        fault_event <= fcu_pkg::fcu_fault_s'(45'h8);
        @(posedge ref_clk);
        fault_event <= '0;
        #1 check(irq, 1'b0, "irq masked");
        @(posedge ref_clk);
        bus(1'b1, fcu_pkg::IDX_IRQ_MASK, 32'h1);
        #1 check(irq, 1'b1, "irq raised");
        @(posedge ref_clk);
        bus(1'b0, fcu_pkg::IDX_IRQ_STATUS, 32'h0);
        check(rd, 64'h1, "status fault bit");
        #1 check(irq, 1'b0, "irq cleared by read");
        check(hresp, 1'b0, "okay response");
        @(posedge ref_clk);
        bus(1'b1, fcu_pkg::IDX_RAIL_CLR, 32'hFF);
        bus(1'b0, fcu_pkg::IDX_NONE, 32'h0);
        check(rd, 64'h0, "unmapped read");
    endtask

    // every clear register: set, write zero, partial clear, read, full clear
    task automatic t_clear();
        logic [63:0] exp;
        for (int k = 0; k < 7; k++) begin
            fault_event <= fcu_pkg::fcu_fault_s'(FW'(64'(EVT[k]) << OFF[k]));
            @(posedge ref_clk);
            fault_event <= '0;
            exp = 64'(MSK[k]) << OFF[k];
            #1 check(64'(fault_flags), exp, "flags set, spare bits stay 0");
            @(posedge ref_clk);
            bus(1'b1, IDX[k], 32'h0);
            #1 check(64'(fault_flags), exp, "zero write keeps flags");
            @(posedge ref_clk);
            bus(1'b1, IDX[k], 32'hA5);
            exp = 64'(MSK[k] & 8'h5A) << OFF[k];
            #1 check(64'(fault_flags), exp, "per-bit clear");
            @(posedge ref_clk);
            bus(1'b0, IDX[k], 32'h0);
            check(rd, 64'h0, "clear register reads zero");
            bus(1'b1, IDX[k], 32'hFF);
            #1 check(64'(fault_flags), 64'h0, "all cleared");
            @(posedge ref_clk);
        end
        // event still present during the clear keeps the flag
        fault_event <= fcu_pkg::fcu_fault_s'(45'h1);
        bus(1'b1, fcu_pkg::IDX_RAIL_CLR, 32'hFF);
        fault_event <= '0;
        #1 check(64'(fault_flags), 64'h1, "present fault sets again");
        @(posedge ref_clk);
        bus(1'b1, fcu_pkg::IDX_RAIL_CLR, 32'h01);
        bus(1'b0, fcu_pkg::IDX_NVLOAD_CLR, 32'h0);
        #1 check(64'(fault_flags), 64'h0, "reread after clear");
        @(posedge ref_clk);
        bus(1'b0, fcu_pkg::IDX_IRQ_STATUS, 32'h0);
    endtask

    // unlock sequence, program start, loss and restarts
    task automatic t_unlock();
        first_stage_ok <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, fcu_pkg::IDX_UNLOCK_1 + 10'(i), 32'hC3);
            bus(1'b0, fcu_pkg::IDX_UNLOCK_1 + 10'(i), 32'h0);
            check(rd, 64'h0, "unlock register reads zero");
        end
        #1 check(program_unlocked, 1'b1, "unlocked");
        @(posedge ref_clk);
        unlock_stat(64'h4);
        bus(1'b1, fcu_pkg::IDX_PROG_CTRL, 32'h1);
        #1 check({program_go, program_unlocked}, 2'b10, "go pulse, lock dropped");
        @(posedge ref_clk);
        #1 check(program_go, 1'b0, "go lasts one cycle");
        @(posedge ref_clk);
        bus(1'b0, fcu_pkg::IDX_IRQ_STATUS, 32'h0);
        check(rd, 64'hA, "status unlock and go");
        wr_list('{fcu_pkg::IDX_UNLOCK_1, fcu_pkg::IDX_UNLOCK_2, fcu_pkg::IDX_UNLOCK_3,
                  fcu_pkg::IDX_UNLOCK_4, fcu_pkg::IDX_RAIL_CLR});
        #1 check(program_unlocked, 1'b0, "any write drops lock");
        @(posedge ref_clk);
        bus(1'b0, fcu_pkg::IDX_IRQ_STATUS, 32'h0);
        check(rd, 64'h6, "status unlock lost");
        wr_list('{fcu_pkg::IDX_UNLOCK_1, fcu_pkg::IDX_UNLOCK_2, fcu_pkg::IDX_NONE,
                  fcu_pkg::IDX_UNLOCK_3, fcu_pkg::IDX_UNLOCK_4});
        unlock_stat(64'h0);
        wr_list('{fcu_pkg::IDX_UNLOCK_4, fcu_pkg::IDX_UNLOCK_3, fcu_pkg::IDX_UNLOCK_2,
                  fcu_pkg::IDX_UNLOCK_1});
        unlock_stat(64'h1);
        wr_list('{fcu_pkg::IDX_UNLOCK_2, fcu_pkg::IDX_UNLOCK_1, fcu_pkg::IDX_UNLOCK_2,
                  fcu_pkg::IDX_UNLOCK_3, fcu_pkg::IDX_UNLOCK_4});
        #1 check(program_unlocked, 1'b1, "restart from first register");
        @(posedge ref_clk);
        first_stage_ok <= 1'b0;
        bus(1'b1, fcu_pkg::IDX_PROG_CTRL, 32'h1);
        repeat (2) @(posedge ref_clk);
        check(go_count, 1, "no start without first stage");
        check(program_unlocked, 1'b0, "lock dropped");
    endtask

    task automatic finish_test();
        $display("checks %0d, errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        rst_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        fault_event = '0;
        first_stage_ok = 1'b0;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        #1 check({fault_flags, program_unlocked, program_go, irq}, 64'h0, "reset outputs");
        check({hreadyout, hresp}, 2'b10, "reset bus outputs");
        @(posedge ref_clk);
        t_irq();
        t_clear();
        t_unlock();
        finish_test();
    end
endmodule
